// ---- rtl/asd_pkg.sv ----
/*
 * Package for the acquisition self-diagnostic block: selector codes, field
 * positions, fixed DAC codes and the packed carriers that join the
 * sequencer to the analog-path control.
 * Assumes one 250 MHz clock and an ADC front end driven by these controls.
 */
package asd_pkg;

    // ****************************************************************
    // selector codes
    // ****************************************************************
    localparam logic [3:0] SEL_NONE       = 4'h0;
    localparam logic [3:0] SEL_ALTERNATE_REFERENCE     = 4'h3;
    localparam logic [3:0] SEL_COMP_PATH  = 4'h4;
    localparam logic [3:0] SEL_GAIN_CAL   = 4'h5;
    localparam logic [3:0] SEL_OFFSET_CAL = 4'h6;
    localparam logic [3:0] SEL_THERMISTOR_SUPPLY_OFS   = 4'h9;

    // scan configuration codes that use the comparator
    localparam logic [2:0] SCFG_COMP_A    = 3'h1;
    localparam logic [2:0] SCFG_COMP_B    = 3'h2;

    // scan style
    localparam logic       STYLE_PYRAMID  = 1'h0;
    localparam logic       STYLE_RAMP     = 1'h1;

    // ****************************************************************
    // widths and field positions
    // ****************************************************************
    localparam int         ADC_W          = 14;
    localparam int         DAC_W          = 10;
    localparam int         RES_LSB        = 2;
    localparam logic [DAC_W-1:0] DAC_COMP_PATH = 10'h1d8;
    localparam logic [1:0] RES_LOW_BITS   = 2'h0;
    localparam logic [ADC_W-1:0] CAL_ZERO = 14'h2000;

    // ****************************************************************
    // carriers
    // ****************************************************************
    typedef enum logic [1:0]
    {
        IN_NONE      = 2'b00,
        IN_REF_AMP1  = 2'b01,
        IN_REF_AMP2  = 2'b10,
        IN_GROUND    = 2'b11
    } asd_route_type;

    typedef struct packed
    {
        asd_route_type    route;       // what feeds the conversion
        logic             preamp_to_adc;
        logic             short_adc;
        logic             bipolar;
        logic             force_pol;
        logic             chop;
        logic             ref_thermistor_supply;
        logic             dac_override;
        logic [DAC_W-1:0] dac_code;
    } asd_path_type;

    typedef struct packed
    {
        logic             valid;
        logic             slot_b;
        logic [ADC_W-1:0] data;
    } asd_conv_type;

    // two-phase chopping repeats a conversion; phase count per request
    function automatic logic two_phase(input logic [3:0] sel,
                                       input logic       style);
        two_phase = (sel == SEL_GAIN_CAL) && (style == STYLE_PYRAMID);
    endfunction

endpackage

// ---- rtl/asd_result_store.sv ----
/*
 * Two diagnostic result words, one per selector slot.
 * Assumes writes come from the sequencer on the same clock.
 */
module asd_result_store
(
    // clock and reset
    input  wire logic                  ref_clk,
    input  wire logic                  rst,
    // write side
    input  wire asd_pkg::asd_conv_type wr,
    // read side
    output logic [15:0]                diag_result_a,
    output logic [15:0]                diag_result_b
);

    typedef struct packed
    {
        logic [15:0] a;
        logic [15:0] b;
    } asd_store_type;

    asd_store_type st_reg;
    asd_store_type st_next;

    always_comb
    begin
        st_next = st_reg;
        if (wr.valid)
        begin
            if (wr.slot_b)
                st_next.b = {wr.data, asd_pkg::RES_LOW_BITS};
            else
                st_next.a = {wr.data, asd_pkg::RES_LOW_BITS};
        end
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    assign diag_result_a = st_reg.a;
    assign diag_result_b = st_reg.b;

    a_slot_a_store: assert property (@(posedge ref_clk) disable iff (rst)
        wr.valid && !wr.slot_b |=> diag_result_a[15:2] == $past(wr.data))
        else $error("slot a result not stored");
    a_slot_b_store: assert property (@(posedge ref_clk) disable iff (rst)
        wr.valid && wr.slot_b |=> diag_result_b[15:2] == $past(wr.data)
                                  && $stable(diag_result_a))
        else $error("slot b result not stored alone");

endmodule

// ---- rtl/asd_diag_seq.sv ----
/*
 * Diagnostic sequencer: per scan request it runs the conversions asked by
 * the two selector slots, sets the analog path for each, stores results,
 * and, for the two comparator scan configurations, runs the comparator accuracy check once after both slot conversions.
 * Assumes the ADC answers each conversion start with one done pulse and
 * that the comparator result is valid with that pulse; all inputs come
 * from logic on ref_clk except the comparator outputs, which are synced.
 */

module asd_diag_seq
(
    // clock and reset
    input  wire logic                     ref_clk,
    input  wire logic                     rst,
    // configuration
    input  wire logic [3:0]               diag_select_slot_a,
    input  wire logic [3:0]               diag_select_slot_b,
    input  wire logic [2:0]               scan_configuration,
    input  wire logic                     scan_sequence_style,
    input  wire logic                     comparator_accuracy_enable,
    input  wire logic                     adc_calibration_enable,
    input  wire logic [9:0]               accuracy_over_threshold,
    input  wire logic [9:0]               accuracy_under_threshold,
    input  wire logic [9:0]               comparator_over_threshold,
    // scan sequencer
    input  wire logic                     scan_start,
    input  wire logic                     oversample_last_done,
    output logic                          diag_busy,
    output logic                          diag_done,
    // adc
    output logic                          adc_start,
    input  wire logic                     adc_done,
    input  wire logic [13:0]              adc_raw,
    input  wire logic [13:0]              adc_cal,
    // comparator (asynchronous pins)
    input  wire logic                     comp_over_pin,
    input  wire logic                     comp_under_pin,
    // analog path control
    output asd_pkg::asd_path_type         path,
    // results and alerts
    output logic [15:0]                   diag_result_a,
    output logic [15:0]                   diag_result_b,
    input  wire logic                     alert_clear,
    output logic                          accuracy_over_alert,
    output logic                          accuracy_under_alert
);

    // ****************************************************************
    // state
    // ****************************************************************
    typedef enum logic [2:0]
    {
        S_IDLE    = 3'b000,
        S_WAIT_OS = 3'b001,
        S_CONV    = 3'b010,
        S_WAIT    = 3'b011,
        S_ACC     = 3'b100,
        S_ACC_W   = 3'b101
    } asd_state_type;

    typedef struct packed
    {
        asd_state_type         st;
        logic                  slot_b;
        logic                  phase2;
        logic                  acc_run;
        logic [13:0]           ph1;
        logic [1:0]            ov_sync;
        logic [1:0]            uv_sync;
        logic                  ov_alert;
        logic                  uv_alert;
        logic                  done;
        asd_pkg::asd_conv_type wr;
    } asd_seq_type;

    asd_seq_type s_reg;
    asd_seq_type s_next;
    logic [3:0]  cur_sel;
    logic [14:0] ph_sum;

    assign cur_sel = s_reg.slot_b ? diag_select_slot_b : diag_select_slot_a;
    assign ph_sum  = {1'b0, s_reg.ph1} + {1'b0, adc_raw};

    // ****************************************************************
    // path control from the active conversion
    // ****************************************************************
    always_comb
    begin
        path = '0;
        path.dac_code = comparator_over_threshold;
        path.chop     = 1'b1;
        if (s_reg.st == S_ACC || s_reg.st == S_ACC_W)
        begin
            path.route        = asd_pkg::IN_REF_AMP2;
            path.dac_override = 1'b1;
            // the over threshold is tried first, then the under one
            path.dac_code     = s_reg.phase2 ? accuracy_under_threshold
                                             : accuracy_over_threshold;
        end
        else if (s_reg.st == S_CONV || s_reg.st == S_WAIT)
        begin
            case (cur_sel)
                asd_pkg::SEL_COMP_PATH:
                begin
                    path.route         = asd_pkg::IN_REF_AMP2;
                    path.preamp_to_adc = 1'b1;
                    path.dac_override  = 1'b1;
                    path.dac_code      = asd_pkg::DAC_COMP_PATH;
                end
                asd_pkg::SEL_GAIN_CAL:
                begin
                    path.route = asd_pkg::IN_REF_AMP1;
                    path.chop  = (scan_sequence_style ==
                                  asd_pkg::STYLE_PYRAMID);
                end
                asd_pkg::SEL_OFFSET_CAL:
                begin
                    path.force_pol = 1'b1;
                    path.bipolar   = 1'b1;
                    path.chop      = 1'b0;
                    if (scan_sequence_style == asd_pkg::STYLE_PYRAMID)
                        path.short_adc = 1'b1;
                    else
                        path.route = asd_pkg::IN_GROUND;
                end
                asd_pkg::SEL_THERMISTOR_SUPPLY_OFS:
                begin
                    path.short_adc = 1'b1;
                    path.ref_thermistor_supply  = 1'b1;
                    path.force_pol = 1'b1;
                    path.bipolar   = 1'b1;
                end
                asd_pkg::SEL_ALTERNATE_REFERENCE:
                begin
                    path.force_pol = 1'b1;
                    path.bipolar   = 1'b0;
                end
                default:
                begin
                    path.route = asd_pkg::IN_NONE;
                end
            endcase
        end
    end

    // ****************************************************************
    // sequencer
    // ****************************************************************
    always_comb
    begin
        s_next          = s_reg;
        s_next.ov_sync  = {s_reg.ov_sync[0], comp_over_pin};
        s_next.uv_sync  = {s_reg.uv_sync[0], comp_under_pin};
        s_next.done     = 1'b0;
        s_next.wr.valid = 1'b0;
        if (alert_clear)
        begin
            s_next.ov_alert = 1'b0;
            s_next.uv_alert = 1'b0;
        end
        case (s_reg.st)
            S_IDLE:
                if (scan_start)
                begin
                    s_next.acc_run = comparator_accuracy_enable &&
                        (scan_configuration == asd_pkg::SCFG_COMP_A ||
                         scan_configuration == asd_pkg::SCFG_COMP_B);
                    s_next.st      = S_WAIT_OS;
                end
            S_WAIT_OS:
                if (oversample_last_done)
                begin
                    s_next.slot_b = 1'b0;
                    s_next.phase2 = 1'b0;
                    s_next.st     = S_CONV;
                end
            S_CONV:
                if (cur_sel == asd_pkg::SEL_NONE)
                begin
                    // an idle slot costs one cycle and no conversion
                    if (s_reg.slot_b)
                        s_next.st = s_reg.acc_run ? S_ACC : S_IDLE;
                    else
                        s_next.slot_b = 1'b1;
                    s_next.done = s_reg.slot_b && !s_reg.acc_run;
                end
                else
                    s_next.st = S_WAIT;
            S_WAIT:
                if (adc_done)
                begin
                    if (asd_pkg::two_phase(cur_sel, scan_sequence_style)
                        && !s_reg.phase2)
                    begin
                        s_next.ph1    = adc_raw;
                        s_next.phase2 = 1'b1;
                        s_next.st     = S_CONV;
                    end
                    else
                    begin
                        s_next.wr.valid  = 1'b1;
                        s_next.wr.slot_b = s_reg.slot_b;
                        if (s_reg.phase2)
                            s_next.wr.data = ph_sum[14:1];
                        else if (cur_sel == asd_pkg::SEL_THERMISTOR_SUPPLY_OFS &&
                                 adc_calibration_enable)
                            s_next.wr.data = adc_cal;
                        else
                            s_next.wr.data = adc_raw;
                        s_next.phase2 = 1'b0;
                        if (s_reg.slot_b)
                        begin
                            s_next.st   = s_reg.acc_run ? S_ACC : S_IDLE;
                            s_next.done = !s_reg.acc_run;
                        end
                        else
                        begin
                            s_next.slot_b = 1'b1;
                            s_next.st     = S_CONV;
                        end
                    end
                end
            S_ACC:
                s_next.st = S_ACC_W;
            S_ACC_W:
                if (adc_done)
                begin
                    if (!s_reg.phase2)
                    begin
                        // set wins over a clear in the same cycle
                        if (s_reg.ov_sync[1])
                            s_next.ov_alert = 1'b1;
                        s_next.phase2 = 1'b1;
                        s_next.st     = S_ACC;
                    end
                    else
                    begin
                        if (s_reg.uv_sync[1])
                            s_next.uv_alert = 1'b1;
                        s_next.phase2 = 1'b0;
                        s_next.done   = 1'b1;
                        s_next.st     = S_IDLE;
                    end
                end
            default:
                s_next.st = S_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            s_reg <= '0;
        else
            s_reg <= s_next;
    end

    asd_result_store u_store
    (
        .ref_clk       (ref_clk),
        .rst           (rst),
        .wr            (s_reg.wr),
        .diag_result_a (diag_result_a),
        .diag_result_b (diag_result_b)
    );

    assign adc_start            = (s_reg.st == S_CONV &&
                                   cur_sel != asd_pkg::SEL_NONE) ||
                                  s_reg.st == S_ACC;
    assign diag_busy            = s_reg.st != S_IDLE;
    assign diag_done            = s_reg.done;
    assign accuracy_over_alert  = s_reg.ov_alert;
    assign accuracy_under_alert = s_reg.uv_alert;

    // ****************************************************************
    // checks
    // ****************************************************************
    a_comp_path_dac: assert property (@(posedge ref_clk) disable iff (rst)
        (s_reg.st == S_WAIT && cur_sel == asd_pkg::SEL_COMP_PATH)
        |-> path.dac_override && path.dac_code == asd_pkg::DAC_COMP_PATH)
        else $error("comparator path dac code wrong");
    a_comp_path_route: assert property (@(posedge ref_clk) disable iff (rst)
        (s_reg.st == S_WAIT && cur_sel == asd_pkg::SEL_COMP_PATH)
        |-> path.preamp_to_adc && path.route == asd_pkg::IN_REF_AMP2)
        else $error("comparator path route wrong");
    a_acc_gate: assert property (@(posedge ref_clk) disable iff (rst)
        (s_reg.st == S_IDLE && scan_start && !comparator_accuracy_enable)
        |=> !s_reg.acc_run)
        else $error("accuracy check armed while disabled");
    a_acc_thresh: assert property (@(posedge ref_clk) disable iff (rst)
        s_reg.st == S_ACC && !s_reg.phase2
        |-> path.dac_code == accuracy_over_threshold
            && path.route == asd_pkg::IN_REF_AMP2)
        else $error("accuracy threshold not applied");
    a_over_alert: assert property (@(posedge ref_clk) disable iff (rst)
        s_reg.st == S_ACC_W && adc_done && !s_reg.phase2 && s_reg.ov_sync[1]
        |=> accuracy_over_alert)
        else $error("over alert not raised");
    a_under_alert: assert property (@(posedge ref_clk) disable iff (rst)
        s_reg.st == S_ACC_W && adc_done && s_reg.phase2 && s_reg.uv_sync[1]
        |=> accuracy_under_alert)
        else $error("under alert not raised");
    a_acc_after_os: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(s_reg.st == S_ACC) |-> $past(s_reg.st) != S_WAIT_OS
            && $past(s_reg.st) != S_IDLE)
        else $error("accuracy check before diag conversions");
    a_offset_bipolar: assert property (@(posedge ref_clk) disable iff (rst)
        (s_reg.st == S_WAIT && cur_sel == asd_pkg::SEL_OFFSET_CAL)
        |-> path.bipolar && path.force_pol && !path.chop)
        else $error("offset diagnostic polarity wrong");
    a_alternate_reference_unipolar: assert property (@(posedge ref_clk) disable iff (rst)
        (s_reg.st == S_WAIT && cur_sel == asd_pkg::SEL_ALTERNATE_REFERENCE)
        |-> path.force_pol && !path.bipolar)
        else $error("alternate reference not unipolar");
    a_thermistor_supply_cal: assert property (@(posedge ref_clk) disable iff (rst)
        s_reg.st == S_WAIT && adc_done && !s_reg.phase2 &&
        cur_sel == asd_pkg::SEL_THERMISTOR_SUPPLY_OFS && adc_calibration_enable
        |=> s_reg.wr.valid && s_reg.wr.data == $past(adc_cal))
        else $error("thermistor result not calibrated");

    c_acc_run: cover property (@(posedge ref_clk) disable iff (rst)
        s_reg.st == S_ACC_W && adc_done && s_reg.phase2);
    c_two_phase: cover property (@(posedge ref_clk) disable iff (rst)
        s_reg.st == S_WAIT && adc_done && s_reg.phase2);
    c_both_slots: cover property (@(posedge ref_clk) disable iff (rst)
        s_reg.wr.valid && s_reg.wr.slot_b);

endmodule

// ---- verification/asd_tb.sv ----
/*
 * Self-checking bench for asd_diag_seq: runs scans, answers each ADC
 * conversion and checks path controls, results and alerts.
 * Assumes the hand-over timing: one adc_start cycle per conversion.
 */
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************************************
    // stimulus and observed signals
    // ****************************************************************
    logic                  ref_clk = 1'b0;
    logic                  rst = 1'b1;
    logic [3:0]            sel_a = 4'h0;
    logic [3:0]            sel_b = 4'h0;
    logic [2:0]            scfg = 3'h0;
    logic                  style = 1'b0;
    logic                  acc_en = 1'b0;
    logic                  cal_en = 1'b1;
    // accuracy thresholds sit five codes either side of the ideal trip
    logic [9:0]            ov_th = 10'h1d3;
    logic [9:0]            uv_th = 10'h1dd;
    logic [9:0]            cmp_th = 10'h155;
    logic                  start = 1'b0;
    logic                  os_done = 1'b0;
    logic                  adc_done = 1'b0;
    logic                  clr = 1'b0;
    logic [13:0]           raw = 14'h0;
    logic [13:0]           cal = 14'h0;
    logic                  pin_ov = 1'b0;
    logic                  pin_uv = 1'b0;
    logic                  busy;
    logic                  done;
    logic                  adc_start;
    logic                  ov_alert;
    logic                  uv_alert;
    logic [15:0]           res_a;
    logic [15:0]           res_b;
    asd_pkg::asd_path_type path;
    asd_pkg::asd_path_type p;
    int                    errors = 0;
    int                    checked = 0;
    int                    starts = 0;

    asd_diag_seq dut
    (
        .ref_clk                    (ref_clk),
        .rst                        (rst),
        .diag_select_slot_a         (sel_a),
        .diag_select_slot_b         (sel_b),
        .scan_configuration         (scfg),
        .scan_sequence_style        (style),
        .comparator_accuracy_enable (acc_en),
        .adc_calibration_enable     (cal_en),
        .accuracy_over_threshold    (ov_th),
        .accuracy_under_threshold   (uv_th),
        .comparator_over_threshold  (cmp_th),
        .scan_start                 (start),
        .oversample_last_done       (os_done),
        .diag_busy                  (busy),
        .diag_done                  (done),
        .adc_start                  (adc_start),
        .adc_done                   (adc_done),
        .adc_raw                    (raw),
        .adc_cal                    (cal),
        .comp_over_pin              (pin_ov),
        .comp_under_pin             (pin_uv),
        .path                       (path),
        .diag_result_a              (res_a),
        .diag_result_b              (res_b),
        .alert_clear                (clr),
        .accuracy_over_alert        (ov_alert),
        .accuracy_under_alert       (uv_alert)
    );

    always #2 ref_clk = ~ref_clk;
    always @(negedge ref_clk)
        if (adc_start === 1'b1)
            starts++;

    // ****************************************************************
    // access and compare tasks
    // ****************************************************************
    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp)
        begin
            errors++;
            $display("Error at %0t: value %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        checked++;
        if (got !== exp)
        begin
            errors++;
            $display("Error at %0t: flag %b expected %b", $time, got, exp);
        end
    endtask

    task automatic wrap_up();
        $display("errors %0d checked %0d", errors, checked);
        if (errors == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic scan_begin();
        starts = 0;
        @(posedge ref_clk);
        start <= 1'b1;
        @(posedge ref_clk);
        start <= 1'b0;
        os_done <= 1'b1;
        @(posedge ref_clk);
        os_done <= 1'b0;
    endtask

    // waits the conversion start, keeps its path, answers with data
    task automatic conv(input logic [13:0] r, input logic [13:0] c);
        int n;
        n = 0;
        @(negedge ref_clk);
        while (adc_start !== 1'b1 && n < 50)
        begin
            n++;
            @(negedge ref_clk);
        end
        chk_bit(adc_start, 1'b1);
        p = path;
        @(posedge ref_clk);
        adc_done <= 1'b1;
        raw <= r;
        cal <= c;
        @(posedge ref_clk);
        adc_done <= 1'b0;
    endtask

    // results land two edges after the last adc_done
    task automatic scan_end();
        int n;
        n = 0;
        @(negedge ref_clk);
        while (done !== 1'b1 && n < 50)
        begin
            n++;
            @(negedge ref_clk);
        end
        chk_bit(done, 1'b1);
        repeat (3) @(negedge ref_clk);
        chk_bit(busy, 1'b0);
    endtask

    // ****************************************************************
    // scenarios
    // ****************************************************************
    initial
    begin
        #40000;
        errors++;
        wrap_up();
    end

    initial
    begin
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        @(negedge ref_clk);
        chk_val(res_a, 16'h0);
        chk_bit(ov_alert, 1'b0);
        chk_val({6'h0, path.dac_code}, {6'h0, cmp_th});
        sel_a <= 4'h4;
        sel_b <= 4'h3;
        acc_en <= 1'b1;
        scan_begin();
        conv(14'h1fec, 14'h1fe0);
        chk_bit(busy, 1'b1);
        chk_bit(p.preamp_to_adc, 1'b1);
        chk_val({14'h0, p.route}, {14'h0, asd_pkg::IN_REF_AMP2});
        chk_val({6'h0, p.dac_code}, 16'h01d8);
        conv(14'h0ffa, 14'h0ff0);
        chk_bit(p.force_pol, 1'b1);
        chk_bit(p.bipolar, 1'b0);
        scan_end();
        chk_val(res_a, {14'h1fec, 2'h0});
        chk_val(res_b, {14'h0ffa, 2'h0});
        chk_val(16'(starts), 16'h2);
        sel_a <= 4'h0;
        sel_b <= 4'h0;
        for (int k = 1; k <= 2; k++)
        begin
            scfg <= 3'(k);
            pin_ov <= (k == 1);
            pin_uv <= (k == 2);
            scan_begin();
            conv(14'h0, 14'h0);
            chk_val({6'h0, p.dac_code}, {6'h0, ov_th});
            chk_val({14'h0, p.route}, {14'h0, asd_pkg::IN_REF_AMP2});
            conv(14'h0, 14'h0);
            chk_val({6'h0, p.dac_code}, {6'h0, uv_th});
            scan_end();
            chk_bit(ov_alert, k == 1);
            chk_bit(uv_alert, k == 2);
            chk_val(16'(starts), 16'h2);
            clr <= 1'b1;
            @(posedge ref_clk);
            clr <= 1'b0;
        end
        acc_en <= 1'b0;
        scan_begin();
        scan_end();
        chk_val(16'(starts), 16'h0);
        chk_bit(uv_alert, 1'b0);
        scfg <= 3'h0;
        sel_a <= 4'h5;
        scan_begin();
        conv(14'h1d88, 14'h1d88);
        chk_val({14'h0, p.route}, {14'h0, asd_pkg::IN_REF_AMP1});
        conv(14'h1d8c, 14'h1d8c);
        scan_end();
        chk_val(res_a, {14'h1d8a, 2'h0});
        style <= 1'b1;
        scan_begin();
        conv(14'h1d90, 14'h1d90);
        scan_end();
        chk_val(16'(starts), 16'h1);
        chk_val(res_a, {14'h1d90, 2'h0});
        sel_a <= 4'h6;
        for (int s = 0; s < 2; s++)
        begin
            style <= s[0];
            scan_begin();
            conv(14'h2001, 14'h2001);
            scan_end();
            chk_bit(p.bipolar && p.force_pol, 1'b1);
            chk_bit(p.chop, 1'b0);
            if (s == 0)
                chk_bit(p.short_adc, 1'b1);
            else
                chk_val({14'h0, p.route}, {14'h0, asd_pkg::IN_GROUND});
        end
        sel_a <= 4'h9;
        for (int e = 0; e < 2; e++)
        begin
            cal_en <= e[0];
            scan_begin();
            conv(14'h2050, 14'h2003);
            scan_end();
            chk_bit(p.ref_thermistor_supply && p.bipolar, 1'b1);
            chk_bit(p.short_adc, 1'b1);
            chk_val(res_a, {e ? 14'h2003 : 14'h2050, 2'h0});
        end
        wrap_up();
    end
endmodule
